// ==== include/pfd_pkg.sv ====
/*
 * package for the loop-2 feedback divider control block: field layout,
 * reset values, interpolation orders and pulse timing.
 * assumes a single 125 MHz clock domain.
 */
package pfd_pkg;
    // ************************************************************
    // register layout (loop2_divider_control)
    // ************************************************************
    localparam int          CTRL_W          = 32;
    localparam int          FRAC_W          = 28;
    localparam int          MOD_W           = 16;
    localparam int          NUM_W           = 16;
    localparam int          MOD_UPPER_W     = 10;
    localparam int          MOD_LOWER_W     = 6;
    localparam int          BIT_FORCE_SYNC  = 12;
    localparam int          BIT_RETARD      = 11;
    localparam int          BIT_RATIONAL    = 10;
    localparam int          BIT_ADVANCE     = 15;
    localparam int          BIT_DIV_RESET   = 14;
    localparam int          MOD_UPPER_LSB   = 0;
    localparam int          INTERP_LSB      = 21;
    localparam int          NUM_LSB         = 9;
    localparam int          MOD_LOWER_LSB   = 0;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [27:0] FRAC_RESET      = 28'h000_0000;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLK_MHZ         = 125;
    localparam int          SYNC_PULSE_NS   = 16;
    localparam int          SYNC_PULSE_CYC  = (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        PFD_INTERP_8    = 2'h0,
        PFD_INTERP_4    = 2'h1,
        PFD_INTERP_2    = 2'h2,
        PFD_INTERP_NONE = 2'h3
    } pfd_interp_t;

    typedef enum logic [1:0] {
        PFD_DIV_FIXED    = 2'h0,
        PFD_DIV_RATIONAL = 2'h1,
        PFD_DIV_INVALID  = 2'h2
    } pfd_div_mode_t;

    // divider settings handed to the analog loop as one coherent word
    typedef struct packed {
        pfd_div_mode_t mode;
        pfd_interp_t   interp;
        logic [15:0]   numerator;
        logic [15:0]   modulus;
        logic [27:0]   fraction;
        logic [2:0]    phase_count;
    } pfd_div_cfg_t;
endpackage : pfd_pkg

// ==== core/pfd_edge_pulse.sv ====
/*
 * rising-edge pulse stretcher: one pulse of PULSE_CYC cycles per rising
 * edge of a level control bit.
 * assumes the level is synchronous to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module pfd_edge_pulse
#(
    parameter int PULSE_CYC = 1
)
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic level_i,
    output logic      rise_o,
    output logic      pulse_o
);
    logic       level_d;
    logic [7:0] cnt;
    logic       next_level_d;
    logic [7:0] next_cnt;

    always_comb
    begin
        next_level_d = level_i;
        next_cnt     = cnt;
        if (level_i && !level_d)
        begin
            next_cnt = 8'(PULSE_CYC);
        end
        else if (cnt != 8'h00)
        begin
            next_cnt = cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            level_d <= 1'b0;
            cnt     <= 8'h00;
        end
        else
        begin
            level_d <= next_level_d;
            cnt     <= next_cnt;
        end
    end

    assign rise_o  = level_i && !level_d;
    assign pulse_o = (cnt != 8'h00);
endmodule // pfd_edge_pulse
`default_nettype wire

// ==== core/pfd_ctrl.sv ====
/*
 * loop-2 feedback divider control: holds the control word, decodes the
 * divider mode, phase steps and sync pulses for the analog loop.
 * assumes the serial configuration port presents whole words with a
 * one-cycle write strobe, and that the fraction word arrives the same way.
 */
`timescale 1ns/100ps
`default_nettype none
module pfd_ctrl
#(
    parameter int PULSE_CYC = pfd_pkg::SYNC_PULSE_CYC
)
(
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 ctrl_we_i,
    input  wire logic [31:0]          ctrl_wdata_i,
    input  wire logic                 frac_we_i,
    input  wire logic [27:0]          frac_wdata_i,
    output logic      [31:0]          ctrl_rdata_o,
    output pfd_pkg::pfd_div_cfg_t     div_cfg_o,
    output logic                      div_reset_o,
    output logic                      sync_pulse_o,
    output logic                      phase_adv_o,
    output logic                      phase_ret_o,
    output logic                      num_over_mod_o
);
    // ************************************************************
    // register storage
    // ************************************************************
    logic [31:0]           ctrl;
    logic [27:0]           frac;
    pfd_pkg::pfd_div_cfg_t cfg;
    logic [31:0]           next_ctrl;
    logic [27:0]           next_frac;
    pfd_pkg::pfd_div_cfg_t next_cfg;
    logic                  adv_rise;
    logic                  ret_rise;
    logic                  adv_pulse_unused;
    logic                  ret_pulse_unused;

    // ************************************************************
    // divider decode
    // ************************************************************
    logic [15:0] modulus;
    logic [15:0] numerator;
    pfd_pkg::pfd_interp_t interp;

    assign modulus   = {ctrl[pfd_pkg::MOD_UPPER_LSB +: pfd_pkg::MOD_UPPER_W],
                        frac[pfd_pkg::MOD_LOWER_LSB +: pfd_pkg::MOD_LOWER_W]};
    assign numerator = frac[pfd_pkg::NUM_LSB +: pfd_pkg::NUM_W];
    assign interp    = pfd_pkg::pfd_interp_t'(ctrl[pfd_pkg::INTERP_LSB +: 2]);

    always_comb
    begin
        next_ctrl = ctrl;
        next_frac = frac;
        if (ctrl_we_i)
        begin
            next_ctrl = ctrl_wdata_i;
        end
        if (frac_we_i)
        begin
            next_frac = frac_wdata_i;
        end
        // whole config rebuilt from stored words each cycle so it changes as one
        next_cfg.modulus   = modulus;
        next_cfg.numerator = numerator;
        next_cfg.fraction  = frac;
        next_cfg.interp    = interp;
        case (interp)
            pfd_pkg::PFD_INTERP_8: next_cfg.phase_count = 3'h0;
            pfd_pkg::PFD_INTERP_4: next_cfg.phase_count = 3'h4;
            pfd_pkg::PFD_INTERP_2: next_cfg.phase_count = 3'h2;
            default:               next_cfg.phase_count = 3'h1;
        endcase
        if (modulus == 16'h0000)
        begin
            next_cfg.mode = pfd_pkg::PFD_DIV_FIXED;
        end
        else if (ctrl[pfd_pkg::BIT_RATIONAL] && numerator > modulus)
        begin
            // passed on flagged rather than blocked, so software can see and fix it
            next_cfg.mode = pfd_pkg::PFD_DIV_INVALID;
        end
        else if (ctrl[pfd_pkg::BIT_RATIONAL])
        begin
            next_cfg.mode = pfd_pkg::PFD_DIV_RATIONAL;
        end
        else
        begin
            next_cfg.mode = pfd_pkg::PFD_DIV_FIXED;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ctrl <= pfd_pkg::CTRL_RESET;
            frac <= pfd_pkg::FRAC_RESET;
            cfg  <= '0;
        end
        else
        begin
            ctrl <= next_ctrl;
            frac <= next_frac;
            cfg  <= next_cfg;
        end
    end

    // ************************************************************
    // phase steps and sync pulses
    // ************************************************************
    pfd_edge_pulse #(.PULSE_CYC(1)) u_adv
    (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .level_i (ctrl[pfd_pkg::BIT_ADVANCE]),
        .rise_o  (adv_rise),
        .pulse_o (adv_pulse_unused)
    );

    pfd_edge_pulse #(.PULSE_CYC(1)) u_ret
    (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .level_i (ctrl[pfd_pkg::BIT_RETARD]),
        .rise_o  (ret_rise),
        .pulse_o (ret_pulse_unused)
    );

    pfd_edge_pulse #(.PULSE_CYC(PULSE_CYC)) u_sync
    (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .level_i (ctrl[pfd_pkg::BIT_FORCE_SYNC]),
        .rise_o  (),
        .pulse_o (sync_pulse_o)
    );

    assign phase_adv_o    = adv_rise;
    assign phase_ret_o    = ret_rise;
    assign div_cfg_o      = cfg;
    assign div_reset_o    = ctrl[pfd_pkg::BIT_DIV_RESET];
    assign ctrl_rdata_o   = ctrl;
    assign num_over_mod_o = (cfg.mode == pfd_pkg::PFD_DIV_INVALID);

    // ************************************************************
    // checks
    // ************************************************************
    AST_RET_ONE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        phase_ret_o |=> !phase_ret_o) else $error("retard step longer than one cycle");
    AST_RET_EDGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        phase_ret_o |-> ctrl[pfd_pkg::BIT_RETARD] && !$past(ctrl[pfd_pkg::BIT_RETARD]))
        else $error("retard step without rising edge");
    AST_ADV_EDGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(ctrl[pfd_pkg::BIT_ADVANCE]) |-> phase_adv_o) else $error("advance edge missed");
    AST_SYNC: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(ctrl[pfd_pkg::BIT_FORCE_SYNC]) |=> sync_pulse_o[*2]) else $error("sync pulse short");
    AST_NUM: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ##1 div_cfg_o.numerator == $past(frac[24:9])) else $error("numerator field wrong");
    AST_MOD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ##1 div_cfg_o.modulus == {$past(ctrl[9:0]), $past(frac[5:0])}) else $error("modulus wrong");
    AST_FIXED: assert property (@(posedge clk_i) disable iff (!rstn_i)
        modulus == 16'h0000 |=> div_cfg_o.mode == pfd_pkg::PFD_DIV_FIXED)
        else $error("zero modulus not fixed point");
    AST_RAT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl[10] && modulus != 16'h0000 && numerator <= modulus
        |=> div_cfg_o.mode == pfd_pkg::PFD_DIV_RATIONAL) else $error("rational mode missed");
    AST_INTERP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl[22:21] == 2'h3 |=> div_cfg_o.phase_count == 3'h1) else $error("interp decode");
    AST_COHERENT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        frac_we_i |=> ##1 div_cfg_o.fraction == $past(frac_wdata_i, 2)) else $error("split update");
    AST_ADV_ONE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        phase_adv_o |=> !phase_adv_o) else $error("advance step longer than one cycle");
    AST_RET_RISE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(ctrl[pfd_pkg::BIT_RETARD]) |-> phase_ret_o) else $error("retard edge missed");
    // written for the default two-cycle sync pulse; a longer pulse needs a deeper look back
    AST_SYNC_QUIET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !ctrl[pfd_pkg::BIT_FORCE_SYNC] && !$past(ctrl[pfd_pkg::BIT_FORCE_SYNC])
        && !$past(ctrl[pfd_pkg::BIT_FORCE_SYNC], 2) |-> !sync_pulse_o)
        else $error("sync pulse without force-sync edge");
    AST_OVER: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl[pfd_pkg::BIT_RATIONAL] && modulus != 16'h0000 && numerator > modulus
        |=> num_over_mod_o) else $error("oversized numerator not flagged");
    AST_NOT_OVER: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !ctrl[pfd_pkg::BIT_RATIONAL] |=> !num_over_mod_o)
        else $error("numerator flag outside rational mode");
    AST_RDATA: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_we_i |=> ctrl_rdata_o == $past(ctrl_wdata_i)) else $error("control readback");
    AST_DIVRST: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_we_i |=> div_reset_o == $past(ctrl_wdata_i[pfd_pkg::BIT_DIV_RESET]))
        else $error("divider reset level");
    AST_INTERP8: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl[22:21] == 2'h0 |=> div_cfg_o.phase_count == 3'h0) else $error("interp8 decode");
    AST_INTERP4: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl[22:21] == 2'h1 |=> div_cfg_o.phase_count == 3'h4) else $error("interp4 decode");
    AST_INTERP2: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl[22:21] == 2'h2 |=> div_cfg_o.phase_count == 3'h2) else $error("interp2 decode");
    AST_FRAC_WORD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        modulus == 16'h0000 |=> div_cfg_o.fraction == $past(frac))
        else $error("fixed-point fraction not passed on");

    // main scenarios reached
    COV_SYNC: cover property (@(posedge clk_i) $rose(sync_pulse_o));
    COV_RAT:  cover property (@(posedge clk_i) div_cfg_o.mode == pfd_pkg::PFD_DIV_RATIONAL);
    COV_RET:  cover property (@(posedge clk_i) phase_ret_o);
    COV_ADV:  cover property (@(posedge clk_i) phase_adv_o);
    COV_OVER: cover property (@(posedge clk_i) num_over_mod_o);
endmodule // pfd_ctrl
`default_nettype wire

// ==== verif/test_pll_feedback_divider_control.sv ====
/*
 * bench for pfd_ctrl: writes control and fraction words, queues notes
 * of the expected results and checks them as the outputs appear.
 * assumes one-cycle readback and two-cycle config latency.
 */
`timescale 1ns/100ps
`default_nettype none
module test_pll_feedback_divider_control;
    localparam int PC = 2;
    typedef struct packed {
        pfd_pkg::pfd_div_cfg_t cfg;
        logic [31:0]           rd;
        logic                  adv;
        logic                  ret;
    } pfd_note_t;
    logic                  clk_i = 1'b0;
    logic                  rstn_i = 1'b0;
    logic                  ctrl_we_i = 1'b0;
    logic [31:0]           ctrl_wdata_i = 32'h0;
    logic                  frac_we_i = 1'b0;
    logic [27:0]           frac_wdata_i = 28'h0;
    logic [31:0]           ctrl_rdata_o;
    pfd_pkg::pfd_div_cfg_t div_cfg_o;
    logic                  div_reset_o;
    logic                  sync_pulse_o;
    logic                  phase_adv_o;
    logic                  phase_ret_o;
    logic                  num_over_mod_o;
    pfd_note_t             notes[$];
    pfd_note_t             nt;
    logic [31:0]           shadow = 32'h0;
    logic [15:0]           lfsr = 16'hA9AC;
    logic [15:0]           r0;
    logic [15:0]           r1;
    logic                  wr_d1 = 1'b0;
    logic                  wr_d2 = 1'b0;
    int                    miscompares = 0;
    int                    n_compared = 0;
    int                    sync_seen = 0;
    int                    sync_exp = 0;
    logic [31:0]           seq [10] = '{32'h0800, 32'h0800, 32'h0, 32'h8800, 32'h8800,
                                        32'hC000, 32'h1000, 32'h1000, 32'h0, 32'h1000};
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

    pfd_ctrl #(.PULSE_CYC(PC)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ctrl_we_i(ctrl_we_i),
        .ctrl_wdata_i(ctrl_wdata_i), .frac_we_i(frac_we_i), .frac_wdata_i(frac_wdata_i),
        .ctrl_rdata_o(ctrl_rdata_o), .div_cfg_o(div_cfg_o), .div_reset_o(div_reset_o),
        .sync_pulse_o(sync_pulse_o), .phase_adv_o(phase_adv_o), .phase_ret_o(phase_ret_o),
        .num_over_mod_o(num_over_mod_o));

    always #4 clk_i = ~clk_i;

    // ************************************************************
    // expectations and drivers
    // ************************************************************
    function automatic logic [15:0] next_rand();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    function automatic pfd_pkg::pfd_div_cfg_t exp_cfg(input logic [31:0] c, input logic [27:0] f);
        pfd_pkg::pfd_div_cfg_t e;
        e.interp = pfd_pkg::pfd_interp_t'(c[22:21]);
        e.numerator = f[24:9];
        e.modulus = {c[9:0], f[5:0]};
        e.fraction = f;
        e.phase_count = (c[22:21] == 2'h0) ? 3'h0 : 3'h4 >> (c[22:21] - 2'h1);
        if (!c[10] || e.modulus == 16'h0)
            e.mode = pfd_pkg::PFD_DIV_FIXED;
        else if (e.numerator > e.modulus)
            e.mode = pfd_pkg::PFD_DIV_INVALID;
        else
            e.mode = pfd_pkg::PFD_DIV_RATIONAL;
        return e;
    endfunction

    // strobes stay high across back-to-back calls, so neither strobe toggles between them
    task automatic wr(input logic [31:0] c, input logic [27:0] f);
        pfd_note_t n;
        n.cfg = exp_cfg(c, f);
        n.rd = c;
        n.adv = c[15] & ~shadow[15];
        n.ret = c[11] & ~shadow[11];
        if (c[12] && !shadow[12])
            sync_exp += PC;
        shadow = c;
        notes.push_back(n);
        ctrl_we_i = 1'b1;
        frac_we_i = 1'b1;
        ctrl_wdata_i = c;
        frac_wdata_i = f;
        @(negedge clk_i);
    endtask

    task automatic idle(input int n);
        ctrl_we_i = 1'b0;
        frac_we_i = 1'b0;
        repeat (n) @(negedge clk_i);
    endtask

    task automatic end_sim;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // monitor
    // ************************************************************
    always @(posedge clk_i)
    begin
        wr_d1 <= ctrl_we_i;
        wr_d2 <= wr_d1;
    end

    // oldest note is popped first so the readback check below sees the next one
    always @(negedge clk_i)
    begin
        if (sync_pulse_o === 1'b1)
            sync_seen++;
        if (wr_d2 && notes.size() > 0)
        begin
            nt = notes.pop_front();
            `CHK("div_cfg", nt.cfg, div_cfg_o)
            `CHK("num_over_mod", nt.cfg.mode == pfd_pkg::PFD_DIV_INVALID, num_over_mod_o)
        end
        if (wr_d1 && notes.size() > 0)
        begin
            `CHK("ctrl_rdata", notes[0].rd, ctrl_rdata_o)
            `CHK("div_reset", notes[0].rd[14], div_reset_o)
            `CHK("phase_adv", notes[0].adv, phase_adv_o)
            `CHK("phase_ret", notes[0].ret, phase_ret_o)
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        repeat (20) @(negedge clk_i);
        rstn_i = 1'b1;
        for (int i = 0; i < 4; i++)
            wr((32'(i) << 21) | 32'h400, 28'hABC_DE00);
        idle(3);
        $display("test interp_fixed done");
        foreach (seq[i])
            wr(seq[i], 28'h0);
        idle(6);
        `CHK("sync_cycles", sync_exp, sync_seen)
        $display("test phase_sync done");
        wr(32'h0060_0401, 28'h000_8000);
        wr(32'h0060_0401, 28'h000_8200);
        wr(32'h0060_0001, 28'h000_8200);
        idle(3);
        $display("test rational done");
        wr(32'h0000_8000, 28'h0);
        idle(3);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK("reset_cfg", exp_cfg(32'h0, 28'h0), div_cfg_o)
        `CHK("reset_rdata", 32'h0, ctrl_rdata_o)
        rstn_i = 1'b1;
        shadow = 32'h0;
        wr(32'h0000_8000, 28'h0);
        idle(3);
        $display("test mid_reset done");
        for (int i = 0; i < 12; i++)
        begin
            r0 = next_rand();
            r1 = next_rand();
            wr({r0, r1}, {r1[11:0], next_rand()});
            idle(2);
        end
        idle(4);
        `CHK("sync_cycles", sync_exp, sync_seen)
        $display("test random done");
        end_sim();
    end

    initial
    begin
        #(8 * 3000);
        miscompares++;
        end_sim();
    end
endmodule // test_pll_feedback_divider_control
`default_nettype wire
